// >>> include/iet_consts.svh
/*
  Constants for the interval timer with edge interrupt: address decode codes,
  field positions, reset values and prescale shifts.
  Assumes inclusion by bare name from design and bench files.
*/
`ifndef IET_CONSTS_SVH
`define IET_CONSTS_SVH

// ----------------------------------------------------------------------------
// address line positions
// ----------------------------------------------------------------------------
`define IET_ADDR_A0 0
`define IET_ADDR_A1 1
`define IET_ADDR_A2 2
`define IET_ADDR_A3 3
`define IET_ADDR_A4 4

// ----------------------------------------------------------------------------
// port register select codes on A1..A0
// ----------------------------------------------------------------------------
`define IET_SEL_PORT_A_OUTPUT 2'h0
`define IET_SEL_PORT_A_DIRECTION 2'h1
`define IET_SEL_PORT_B_OUTPUT 2'h2
`define IET_SEL_PORT_B_DIRECTION 2'h3

// ----------------------------------------------------------------------------
// prescale codes on A1..A0 and their shift (unit = 1 << shift clock periods)
// ----------------------------------------------------------------------------
`define IET_PRESCALE_DIV1 2'h0
`define IET_PRESCALE_DIV8 2'h1
`define IET_PRESCALE_DIV64 2'h2
`define IET_PRESCALE_DIV1024 2'h3
`define IET_SHIFT_DIV1 0
`define IET_SHIFT_DIV8 3
`define IET_SHIFT_DIV64 6
`define IET_SHIFT_DIV1024 10

// ----------------------------------------------------------------------------
// flag register layout
// ----------------------------------------------------------------------------
`define IET_FLAG_TIMER_BIT 7
`define IET_FLAG_EDGE_BIT 6

// ----------------------------------------------------------------------------
// reset values and counter constants
// ----------------------------------------------------------------------------
`define IET_PORT_RESET 8'h00
`define IET_COUNTER_RESET 8'h00
`define IET_COUNTER_WRAP 8'hFF
`define IET_COUNTER_FLOOR 8'h00
`define IET_PRESCALE_RESET 10'h000

`endif

// >>> include/iet_pkg.sv
/*
  Types for the interval timer with edge interrupt: bus request carrier and
  decoded access target.
  Assumes iet_consts.svh is available on the include path.
*/
package iet_pkg;

  // ----------------------------------------------------------------------------
  // bus request as seen in one clock cycle
  // ----------------------------------------------------------------------------
  typedef struct packed {
    logic selected;
    logic io_space;
    logic read;
    logic [6:0] addr;
    logic [7:0] wdata;
  } iet_bus_req_type;

  // ----------------------------------------------------------------------------
  // decoded target of an access
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    IET_TGT_NONE,
    IET_TGT_RAM,
    IET_TGT_PORT,
    IET_TGT_TIMER_LOAD,
    IET_TGT_EDGE_CTRL,
    IET_TGT_TIMER_READ,
    IET_TGT_FLAG_READ
  } iet_target_type;

endpackage : iet_pkg

// >>> hdl/iet_timer.sv
/*
  Interval timer with prescaler, two-bit flag register, edge interrupt on the
  top line of port A, port registers, 128-byte RAM and the address decode.
  Assumes the processor bus runs on sys_clk, one access per cycle while
  selected; port pins arrive asynchronously; the interrupt line is pulled up
  outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iet_consts.svh"

module iet_timer #(
  parameter int RAM_DEPTH = 128
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic chip_select_active_high,
  input wire logic chip_select_active_low,
  input wire logic ram_or_io_select_n,
  input wire logic read_not_write,
  input wire logic [6:0] addr,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic irq_n_out,
  output logic irq_n_oe
);

  // ----------------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------------

  logic [1:0] rst_sync_r;
  logic rst_n;

  // assert at once, release through two flops so no flop sees a runt edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------------

  // last prescale count for a code; unit length is this plus one
  function automatic logic [9:0] prescale_last(input logic [1:0] code);
    logic [9:0] last;
    last = 10'h000;
    unique case (code)
      `IET_PRESCALE_DIV1: last = 10'((1 << `IET_SHIFT_DIV1) - 1);
      `IET_PRESCALE_DIV8: last = 10'((1 << `IET_SHIFT_DIV8) - 1);
      `IET_PRESCALE_DIV64: last = 10'((1 << `IET_SHIFT_DIV64) - 1);
      `IET_PRESCALE_DIV1024: last = 10'((1 << `IET_SHIFT_DIV1024) - 1);
    endcase
    return last;
  endfunction : prescale_last

  // decode of one bus cycle into its target
  function automatic iet_pkg::iet_target_type decode_target(input iet_pkg::iet_bus_req_type req);
    iet_pkg::iet_target_type tgt;
    tgt = iet_pkg::IET_TGT_NONE;
    if (req.selected) begin
      if (!req.io_space) begin
        tgt = iet_pkg::IET_TGT_RAM;
      end else if (!req.addr[`IET_ADDR_A2]) begin
        tgt = iet_pkg::IET_TGT_PORT;
      end else if (req.read) begin
        tgt = req.addr[`IET_ADDR_A0] ? iet_pkg::IET_TGT_FLAG_READ : iet_pkg::IET_TGT_TIMER_READ;
      end else begin
        tgt = req.addr[`IET_ADDR_A4] ? iet_pkg::IET_TGT_TIMER_LOAD : iet_pkg::IET_TGT_EDGE_CTRL;
      end
    end
    return tgt;
  endfunction : decode_target

  // ----------------------------------------------------------------------------
  // bus request and decode
  // ----------------------------------------------------------------------------

  iet_pkg::iet_bus_req_type req;
  iet_pkg::iet_target_type tgt;
  logic timer_access;
  logic [1:0] port_sel;

  assign req.selected = chip_select_active_high & ~chip_select_active_low;
  assign req.io_space = ram_or_io_select_n;
  assign req.read = read_not_write;
  assign req.addr = addr;
  assign req.wdata = data_in;

  assign tgt = decode_target(req);
  assign timer_access = (tgt == iet_pkg::IET_TGT_TIMER_LOAD) || (tgt == iet_pkg::IET_TGT_TIMER_READ);
  assign port_sel = addr[`IET_ADDR_A1:`IET_ADDR_A0];

  // ----------------------------------------------------------------------------
  // port pin synchronisers
  // ----------------------------------------------------------------------------

  logic [7:0] pa_s1_r, pa_s2_r, pa_s3_r, pa_stable_r;

  // three stages; a change is taken only once stages two and three agree
  // stages reset to the idle high level of the filter, so release makes no false edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_s1_r <= 8'hFF;
      pa_s2_r <= 8'hFF;
      pa_s3_r <= 8'hFF;
    end else begin
      pa_s1_r <= port_a_in;
      pa_s2_r <= pa_s1_r;
      pa_s3_r <= pa_s2_r;
    end
  end

  // per-bit filter on the agreeing stages
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pa_filter
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          pa_stable_r[gi] <= 1'b1;
        end else if (pa_s2_r[gi] == pa_s3_r[gi]) begin
          pa_stable_r[gi] <= pa_s3_r[gi];
        end
      end
    end
  endgenerate

  // port B pins are never read back, so they need no synchroniser
  logic [7:0] unused_port_b;
  assign unused_port_b = port_b_in;

  // ----------------------------------------------------------------------------
  // port registers
  // ----------------------------------------------------------------------------

  logic [7:0] port_a_output_reg_r, port_a_direction_reg_r;
  logic [7:0] port_b_output_reg_r, port_b_direction_reg_r;

  // all cleared at reset, every line an input
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_a_output_reg_r <= `IET_PORT_RESET;
      port_a_direction_reg_r <= `IET_PORT_RESET;
      port_b_output_reg_r <= `IET_PORT_RESET;
      port_b_direction_reg_r <= `IET_PORT_RESET;
    end else if (tgt == iet_pkg::IET_TGT_PORT && !req.read) begin
      unique case (port_sel)
        `IET_SEL_PORT_A_OUTPUT: port_a_output_reg_r <= data_in;
        `IET_SEL_PORT_A_DIRECTION: port_a_direction_reg_r <= data_in;
        `IET_SEL_PORT_B_OUTPUT: port_b_output_reg_r <= data_in;
        `IET_SEL_PORT_B_DIRECTION: port_b_direction_reg_r <= data_in;
      endcase
    end
  end

  // direction bit enables the driver of its output bit
  assign port_a_out = port_a_output_reg_r;
  assign port_a_oe = port_a_direction_reg_r;
  assign port_b_out = port_b_output_reg_r;
  assign port_b_oe = port_b_direction_reg_r;

  // ----------------------------------------------------------------------------
  // RAM
  // ----------------------------------------------------------------------------

  logic [7:0] ram_mem [RAM_DEPTH];
  logic [6:0] ram_index;

  assign ram_index = addr;

  // contents are undefined after power up, as with any static RAM
  always_ff @(posedge sys_clk) begin
    if (tgt == iet_pkg::IET_TGT_RAM && !req.read) begin
      ram_mem[ram_index] <= data_in;
    end
  end

  // ----------------------------------------------------------------------------
  // interval timer
  // ----------------------------------------------------------------------------

  logic [7:0] counter_r;
  logic [1:0] prescale_code_r;
  logic [9:0] prescale_cnt_r;
  logic timed_out_r;
  logic timer_irq_en_r;
  logic step;
  logic timeout_evt;

  // one step per unit; after timeout every period is a step
  assign step = timed_out_r | (prescale_cnt_r == prescale_last(prescale_code_r));
  // step while at zero is the timeout
  assign timeout_evt = step & ~timed_out_r & (counter_r == `IET_COUNTER_FLOOR);

  // prescale divider, restarted by every load so the first unit is whole
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale_cnt_r <= `IET_PRESCALE_RESET;
    end else if (tgt == iet_pkg::IET_TGT_TIMER_LOAD || step) begin
      prescale_cnt_r <= `IET_PRESCALE_RESET;
    end else begin
      prescale_cnt_r <= prescale_cnt_r + 10'h001;
    end
  end

  // data byte is the interval count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      counter_r <= `IET_COUNTER_RESET;
      prescale_code_r <= `IET_PRESCALE_DIV1;
      timed_out_r <= 1'b0;
    end else if (tgt == iet_pkg::IET_TGT_TIMER_LOAD) begin
      counter_r <= data_in;
      prescale_code_r <= addr[`IET_ADDR_A1:`IET_ADDR_A0];
      timed_out_r <= 1'b0;
    end else if (timeout_evt) begin
      counter_r <= `IET_COUNTER_WRAP;
      timed_out_r <= 1'b1;
    end else if (step && !(timed_out_r && counter_r == `IET_COUNTER_FLOOR)) begin
      // stops at the floor, 255 periods after the wrap
      counter_r <= counter_r - 8'h01;
    end
  end

  // enable follows A3 on every timer read or write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_irq_en_r <= 1'b0;
    end else if (timer_access) begin
      timer_irq_en_r <= addr[`IET_ADDR_A3];
    end
  end

  // ----------------------------------------------------------------------------
  // flags and edge detector
  // ----------------------------------------------------------------------------

  logic timer_flag_r;
  logic edge_flag_r;
  logic edge_irq_en_r;
  logic edge_positive_r;
  logic top_line_prev_r;
  logic edge_evt;

  // set on timeout whatever the enable
  // set wins over a clearing access in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_flag_r <= 1'b0;
    end else if (timeout_evt) begin
      timer_flag_r <= 1'b1;
    end else if (timer_access) begin
      timer_flag_r <= 1'b0;
    end
  end

  // edge control write, data lines ignored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_irq_en_r <= 1'b0;
      edge_positive_r <= 1'b0;
    end else if (tgt == iet_pkg::IET_TGT_EDGE_CTRL) begin
      edge_irq_en_r <= addr[`IET_ADDR_A1];
      edge_positive_r <= addr[`IET_ADDR_A0];
    end
  end

  // previous filtered level of the top line
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      top_line_prev_r <= 1'b1;
    end else begin
      top_line_prev_r <= pa_stable_r[7];
    end
  end

  // sensed from the pin level, direction plays no part
  assign edge_evt = edge_positive_r ? (pa_stable_r[7] & ~top_line_prev_r) : (~pa_stable_r[7] & top_line_prev_r);

  // flag read clears; a coincident edge still wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_flag_r <= 1'b0;
    end else if (edge_evt) begin
      edge_flag_r <= 1'b1;
    end else if (tgt == iet_pkg::IET_TGT_FLAG_READ) begin
      edge_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt request pin
  // ----------------------------------------------------------------------------

  // timer source gated by its enable
  // open drain: only ever pulls low, pull-up is external
  assign irq_n_out = 1'b0;
  assign irq_n_oe = (timer_flag_r & timer_irq_en_r) | (edge_flag_r & edge_irq_en_r);

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------

  logic [7:0] read_mux;
  logic [7:0] flag_value;
  logic [7:0] data_out_r;
  logic data_oe_r;

  // both flags on their bits, others zero
  always_comb begin
    flag_value = 8'h00;
    flag_value[`IET_FLAG_TIMER_BIT] = timer_flag_r;
    flag_value[`IET_FLAG_EDGE_BIT] = edge_flag_r;
  end

  // timer section read picks on A0
  always_comb begin
    read_mux = 8'h00;
    unique case (tgt)
      iet_pkg::IET_TGT_RAM: read_mux = ram_mem[ram_index];
      iet_pkg::IET_TGT_PORT: begin
        unique case (port_sel)
          // port A reads the filtered pin levels
          `IET_SEL_PORT_A_OUTPUT: read_mux = pa_stable_r;
          `IET_SEL_PORT_A_DIRECTION: read_mux = port_a_direction_reg_r;
          // port B reads the register, immune to heavy pin loading
          `IET_SEL_PORT_B_OUTPUT: read_mux = port_b_output_reg_r;
          `IET_SEL_PORT_B_DIRECTION: read_mux = port_b_direction_reg_r;
        endcase
      end
      // after timeout the same byte reads as a negative count
      iet_pkg::IET_TGT_TIMER_READ: read_mux = counter_r;
      iet_pkg::IET_TGT_FLAG_READ: read_mux = flag_value;
      default: read_mux = 8'h00;
    endcase
  end

  // answer one cycle after the access, held off outside read cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out_r <= 8'h00;
      data_oe_r <= 1'b0;
    end else begin
      data_oe_r <= req.selected & req.read;
      if (req.selected && req.read) begin
        data_out_r <= read_mux;
      end
    end
  end

  assign data_out = data_out_r;
  assign data_oe = data_oe_r;

endmodule : iet_timer

`default_nettype wire

// >>> sim/iet_pins.sv
/*
  Far-side model: the port pins and the shared interrupt line as the
  peripherals and the processor see them.
  Assumes the bench supplies the external drive levels for both ports.
*/
`timescale 1ns/1ps
`default_nettype none

module iet_pins (
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_b_oe,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_b,
  output logic [7:0] pin_a,
  output logic [7:0] pin_b,
  output logic irq_line
);
  // ---------------------------------------------------------------------------
  // pin resolution
  // ---------------------------------------------------------------------------
  // output lines win
  assign pin_a = (port_a_oe & port_a_out) | (~port_a_oe & ext_a);
  assign pin_b = (port_b_oe & port_b_out) | (~port_b_oe & ext_b);
  assign irq_line = irq_n_oe ? irq_n_out : 1'b1; // wired line idles high
endmodule : iet_pins

`default_nettype wire

// >>> sim/iet_timer_props.sv
/*
  Checker for the interval timer: bus answer, port register loads and the
  open-drain interrupt output.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module iet_timer_props #(
  parameter int RAM_DEPTH = 128
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic chip_select_active_high,
  input wire logic chip_select_active_low,
  input wire logic ram_or_io_select_n,
  input wire logic read_not_write,
  input wire logic [6:0] addr,
  input wire logic [7:0] data_in,
  input wire logic data_oe,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe,
  input wire logic [7:0] port_b_out,
  input wire logic irq_n_out,
  input wire logic irq_n_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic sel;
  logic wr_io;
  // both selects must agree before anything is an access
  assign sel = chip_select_active_high && !chip_select_active_low;
  assign wr_io = sel && ram_or_io_select_n && !read_not_write;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  a_read_answer: assert property (sel && read_not_write |=> data_oe)
    else $error("read not answered next cycle");
  a_oe_cause: assert property (data_oe |-> $past(sel && read_not_write))
    else $error("data driven without a read");
  a_irq_open_drain: assert property (irq_n_oe |-> !irq_n_out)
    else $error("interrupt line driven high");
  a_dir_a_load: assert property (wr_io && addr[2:0] == 3'h1 |=> port_a_oe == $past(data_in))
    else $error("port A direction not loaded");
  a_out_b_load: assert property (wr_io && addr[2:0] == 3'h2 |=> port_b_out == $past(data_in))
    else $error("port B output not loaded");
  a_dir_a_hold: assert property (!$stable(port_a_oe) |-> $past(wr_io && addr[2:0] == 3'h1))
    else $error("port A direction changed unasked");
  a_ram_ports_hold: assert property (sel && !ram_or_io_select_n |=> $stable(port_a_out) && $stable(port_b_out))
    else $error("memory access touched ports");
  a_timer_ports_hold: assert property (sel && ram_or_io_select_n && addr[2] |=> $stable(port_a_oe) && $stable(port_b_out))
    else $error("timer access touched ports");

  // ---------------------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------------------
  c_flag_read: cover property (sel && ram_or_io_select_n && read_not_write && addr[2] && addr[0]);
  c_edge_ctrl: cover property (wr_io && addr[2] && !addr[4]);
  c_irq_rise: cover property ($rose(irq_n_oe));
endmodule : iet_timer_props

bind iet_timer iet_timer_props #(.RAM_DEPTH(RAM_DEPTH)) iet_timer_props_i (
  .sys_clk(sys_clk), .nrst(nrst), .chip_select_active_high(chip_select_active_high),
  .chip_select_active_low(chip_select_active_low), .ram_or_io_select_n(ram_or_io_select_n),
  .read_not_write(read_not_write), .addr(addr), .data_in(data_in), .data_oe(data_oe),
  .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_b_out(port_b_out),
  .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

`default_nettype wire

// >>> sim/tb.sv
/*
  Self-checking bench for the interval timer: ports, memory, timer at every
  prescale, timer flag and interrupt, edge flag in both modes.
  Assumes the design answers reads one cycle after the access edge.
*/
`timescale 1ns/1ps
`default_nettype none
`include "iet_consts.svh"

module tb;
  logic sys_clk = 1'b0;
  logic nrst, csh, csl, rs, rnw, data_oe, irq_n_out, irq_n_oe, irq_line;
  logic [6:0] addr;
  logic [7:0] din, data_out, port_a_out, port_a_oe, port_b_out, port_b_oe;
  logic [7:0] ext_a, ext_b, pin_a, pin_b, rv;
  logic [7:0] pv [4];
  logic [15:0] rnd;
  logic [7:0] expq [$];
  int cyc = 0;
  int failures = 0;
  int n_compared = 0;
  int tl, tt, n;
  int sh [4] = '{`IET_SHIFT_DIV1, `IET_SHIFT_DIV8, `IET_SHIFT_DIV64, `IET_SHIFT_DIV1024};

  iet_timer iet_timer_i (.sys_clk(sys_clk), .nrst(nrst), .chip_select_active_high(csh),
    .chip_select_active_low(csl), .ram_or_io_select_n(rs), .read_not_write(rnw), .addr(addr),
    .data_in(din), .data_out(data_out), .data_oe(data_oe), .port_a_in(pin_a),
    .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_b_in(pin_b), .port_b_out(port_b_out),
    .port_b_oe(port_b_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));
  iet_pins iet_pins_i (.port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_b_out(port_b_out),
    .port_b_oe(port_b_oe), .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .ext_a(ext_a),
    .ext_b(ext_b), .pin_a(pin_a), .pin_b(pin_b), .irq_line(irq_line));

  // ---------------------------------------------------------------------------
  // clock, edge count, helpers
  // ---------------------------------------------------------------------------
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // one access taken at the next rising edge; on return cyc is that edge
  task automatic acc(input logic r, input logic s, input logic [6:0] a, input logic [7:0] d);
    csh = 1'b1;
    csl = 1'b0;
    rs = s;
    rnw = r;
    addr = a;
    din = d;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : acc

  task automatic rd(input logic s, input logic [6:0] a, input logic [7:0] e);
    expq.push_back(e);
    acc(1'b1, s, a, 8'h00);
  endtask : rd

  // write with the low-active select left high, which must be ignored
  task automatic nsel(input logic s, input logic [6:0] a, input logic [7:0] d);
    csh = 1'b1;
    csl = 1'b1;
    rs = s;
    rnw = 1'b0;
    addr = a;
    din = d;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : nsel

  task automatic idle(input int k);
    repeat (k) begin
      csh = 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
    end
  endtask : idle

  // park until the next access lands exactly on edge e
  task automatic upto(input int e);
    while (cyc + 1 < e) idle(1);
  endtask : upto

  // ---------------------------------------------------------------------------
  // read data monitor: every read strobe consumes the oldest expectation
  // ---------------------------------------------------------------------------
  always @(negedge sys_clk) begin
    if (data_oe === 1'b1) begin
      if (expq.size() == 0) check("unexpected read strobe", 8'h01, 8'h00);
      else check("read data", data_out, expq.pop_front());
    end
  end

  // a hang would otherwise never reach the verdict
  initial begin
    repeat (30000) @(posedge sys_clk);
    failures++;
    give_verdict();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    nrst = 1'b0; csh = 1'b0; csl = 1'b1; rs = 1'b0; rnw = 1'b1;
    addr = 7'h00; din = 8'h00; ext_a = 8'hFF; ext_b = 8'h00; rnd = 16'h7E99;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    idle(3);
    // timer ran out from reset with its output disabled; ports are inputs
    rd(1'b1, 7'h05, 8'h80);
    check("irq after reset", {7'h00, irq_n_oe}, 8'h00);
    for (int i = 1; i < 4; i++) rd(1'b1, 7'(i), 8'h00);
    // port registers with random contents, top line of A kept an input
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      pv[i] = rnd[7:0];
      if (i == 1) pv[i][7] = 1'b0;
      acc(1'b0, 1'b1, 7'(i), pv[i]);
    end
    nsel(1'b1, 7'h02, ~pv[2]);
    check("port A out", port_a_out, pv[0]);
    check("port A dir", port_a_oe, pv[1]);
    check("port B out", port_b_out, pv[2]);
    check("port B dir", port_b_oe, pv[3]);
    ext_b = ~pv[2];
    rd(1'b1, 7'h02, pv[2]);
    rd(1'b1, 7'h01, pv[1]);
    rd(1'b1, 7'h03, pv[3]);
    // port A reads the lines: outputs show the register, inputs the pulled-high pins
    rd(1'b1, 7'h00, (pv[1] & pv[0]) | ~pv[1]);
    // memory, with an ignored deselected write in between
    rnd = lfsr(rnd);
    acc(1'b0, 1'b0, rnd[6:0], rnd[15:8]);
    nsel(1'b0, rnd[6:0], ~rnd[15:8]);
    rd(1'b0, rnd[6:0], rnd[15:8]);
    // every prescale: load 2 intervals, output off, timeout at 3 units
    for (int c = 0; c < 4; c++) begin
      n = 1 << sh[c];
      acc(1'b0, 1'b1, 7'h14 + 7'(c), 8'h02);
      tl = cyc;
      tt = tl + 3 * n;
      rd(1'b1, 7'h04, 8'h02);
      upto(tt - 1);
      rd(1'b1, 7'h05, 8'h00);
      upto(tt + 1);
      rd(1'b1, 7'h05, 8'h80);
      upto(tt + 3);
      rd(1'b1, 7'h04, 8'hFD);
      rd(1'b1, 7'h05, 8'h00);
    end
    // output enabled, timer read lands on the timeout edge itself
    acc(1'b0, 1'b1, 7'h1C, 8'h01);
    tt = cyc + 2;
    upto(tt);
    rd(1'b1, 7'h0C, 8'h00);
    rd(1'b1, 7'h05, 8'h80);
    check("irq on timeout", {7'h00, irq_n_oe}, 8'h01);
    check("irq line low", {7'h00, irq_line}, 8'h00);
    // read back with the output disabled
    rd(1'b1, 7'h04, 8'hFE);
    idle(1);
    check("irq after read", {7'h00, irq_n_oe}, 8'h00);
    // falling pin in the reset mode: flag only, no request
    ext_a = 8'h7F;
    idle(8);
    check("edge irq off", {7'h00, irq_n_oe}, 8'h00);
    rd(1'b1, 7'h05, 8'h40);
    rd(1'b1, 7'h05, 8'h00);
    // rising edge made by the block itself with the line as output
    rnd = lfsr(rnd);
    acc(1'b0, 1'b1, 7'h07, rnd[7:0]);
    acc(1'b0, 1'b1, 7'h00, 8'h00);
    acc(1'b0, 1'b1, 7'h01, 8'h80);
    acc(1'b0, 1'b1, 7'h00, 8'h80);
    idle(8);
    check("edge irq on", {7'h00, irq_n_oe}, 8'h01);
    rd(1'b1, 7'h05, 8'h40);
    idle(1);
    check("edge irq cleared", {7'h00, irq_n_oe}, 8'h00);
    acc(1'b0, 1'b1, 7'h00, 8'h00);
    idle(8);
    rd(1'b1, 7'h05, 8'h00);
    idle(2);
    check("pending reads", 8'(expq.size()), 8'h00);
    give_verdict();
  end
endmodule : tb

`default_nettype wire
